// ==== mcs_top.sv ====
/*
 * Motor current hold/run sequencer for one axis, with its registers.
 * Assumes stst, motion_req and silent_mode come from logic on core_clk.
 */
// Design decision made here: the AXI4-Lite register port.
// Functional notes
// - Ramp up in steps, delay times 512 clocks.
// - Ramp down in steps of 2^18 clock multiples.
// - Ramp down only after standstill and power-down delay.
// - Run scale is (n+1)/32 of full scale.
// - Hold scale is (n+1)/32 of full scale.
// - Silent mode, hold zero: freewheel or short coils.
// - Power-down delay in 2^18 clock units, reset ten.
`timescale 1ns/1ps
module mcs_top
   import mcs_pkg::*;
#(
   parameter int LONG_UNIT_CYC = DN_UNIT_CLK
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              stst,
   input  wire logic              motion_req,
   input  wire logic              silent_mode,
   output logic [5:0]             cur_scale,
   output logic [1:0]             coil_mode,
   output logic                   motion_go
);

   // ------------------------------------------------------------
   // Helpers.
   // ------------------------------------------------------------
   function automatic logic reg_hit(input logic [IDX_W-1:0] idx);
      reg_hit = (idx == IDX_LEVELS) || (idx == IDX_PDOWN) ||
                (idx == IDX_CTRL) || (idx == IDX_STATUS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   function automatic logic [4:0] step_toward(input logic [4:0] cur,
                                              input logic [4:0] tgt);
      if (cur < tgt) begin
         step_toward = cur + 5'h01;
      end else if (cur > tgt) begin
         step_toward = cur - 5'h01;
      end else begin
         step_toward = cur;
      end
   endfunction

   // ------------------------------------------------------------
   // Register file.
   // ------------------------------------------------------------
   logic             wr_en, wr_ok, rd_ok;
   logic [IDX_W-1:0] wr_idx, rd_idx;
   logic [31:0]      wr_data, rd_data;
   logic [3:0]       wr_strb;
   logic [31:0]      levels, next_levels, pdown, next_pdown;
   logic [31:0]      ctrl, next_ctrl;
   logic [3:0]       upd, dnd;
   logic [4:0]       run, hold;
   logic [7:0]       pd;

   mcs_axil_slave u_bus (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .awaddr   (s_axi_awaddr),
      .awvalid  (s_axi_awvalid),
      .awready  (s_axi_awready),
      .wdata    (s_axi_wdata),
      .wstrb    (s_axi_wstrb),
      .wvalid   (s_axi_wvalid),
      .wready   (s_axi_wready),
      .bresp    (s_axi_bresp),
      .bvalid   (s_axi_bvalid),
      .bready   (s_axi_bready),
      .araddr   (s_axi_araddr),
      .arvalid  (s_axi_arvalid),
      .arready  (s_axi_arready),
      .rdata    (s_axi_rdata),
      .rresp    (s_axi_rresp),
      .rvalid   (s_axi_rvalid),
      .rready   (s_axi_rready),
      .wr_en    (wr_en),
      .wr_idx   (wr_idx),
      .wr_data  (wr_data),
      .wr_strb  (wr_strb),
      .wr_ok    (wr_ok),
      .rd_idx   (rd_idx),
      .rd_data  (rd_data),
      .rd_ok    (rd_ok)
   );

   assign upd  = levels[UPD_LSB +: 4];
   assign dnd  = levels[DND_LSB +: 4];
   assign run  = levels[RUN_LSB +: 5];
   assign hold = levels[HOLD_LSB +: 5];
   assign pd   = pdown[PD_LSB +: 8];
   assign wr_ok = reg_hit(wr_idx);
   assign rd_ok = reg_hit(rd_idx);

   mcs_state_t state, next_state;
   logic [4:0] level, next_level;

   always_comb begin
      next_levels = levels;
      next_pdown  = pdown;
      next_ctrl   = ctrl;
      if (wr_en && wr_idx == IDX_LEVELS) begin
         next_levels = merge(levels, wr_data, wr_strb) & LEVELS_MASK;
      end
      if (wr_en && wr_idx == IDX_PDOWN) begin
         next_pdown = merge(pdown, wr_data, wr_strb) & PDOWN_MASK;
      end
      if (wr_en && wr_idx == IDX_CTRL) begin
         next_ctrl = merge(ctrl, wr_data, wr_strb) & CTRL_MASK;
      end
      case (rd_idx)
         IDX_LEVELS: rd_data = levels;
         IDX_PDOWN:  rd_data = pdown;
         IDX_CTRL:   rd_data = ctrl;
         IDX_STATUS: begin
            rd_data = 32'h0000_0000;
            rd_data[HOLD_LSB +: 5] = level;
            rd_data[ST_LSB +: 3]   = state;
            rd_data[GO_BIT]        = motion_go;
         end
         default:    rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         levels <= {4'h0, UPD_RST, 4'h0, DND_RST, 3'h0, RUN_RST,
                    3'h0, HOLD_RST};
         pdown  <= {24'h00_0000, PD_RST};
         ctrl   <= 32'h0000_0000;
      end else if (ce) begin
         levels <= next_levels;
         pdown  <= next_pdown;
         ctrl   <= next_ctrl;
      end
   end

   // ------------------------------------------------------------
   // Sequencer.
   // ------------------------------------------------------------
   logic           step_start, step_done, pd_start, pd_done, step_long;
   logic [7:0]     step_units;
   logic [5:0]     next_scale;
   logic [1:0]     next_coil;

   // Step length is chosen from the state being entered, so the first
   // step is already timed with the right unit.
   assign step_long  = (next_state == ST_RAMP_DOWN);
   assign step_units = step_long ? {4'h0, dnd} : {4'h0, upd};

   mcs_unit_timer u_step (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .start    (step_start),
      .units    (step_units),
      .unit_len (step_long ? CNT_W'(LONG_UNIT_CYC) : CNT_W'(UP_UNIT_CLK)),
      .done     (step_done)
   );

   mcs_unit_timer u_pdown (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .start    (pd_start),
      .units    (pd),
      .unit_len (CNT_W'(LONG_UNIT_CYC)),
      .done     (pd_done)
   );

   always_comb begin
      next_state = state;
      next_level = level;
      step_start = 1'b0;
      pd_start   = 1'b0;
      case (state)
         ST_HOLD: begin
            next_level = hold;
            if (motion_req) begin
               if (upd == 4'h0) begin
                  next_level = run;
                  next_state = ST_RUN;
               end else begin
                  next_state = ST_RAMP_UP;
                  step_start = 1'b1;
               end
            end
         end
         ST_RAMP_UP: begin
            if (upd == 4'h0 || level == run) begin
               next_level = run;
               next_state = ST_RUN;
            end else if (step_done) begin
               next_level = step_toward(level, run);
               step_start = 1'b1;
            end
         end
         ST_RUN: begin
            next_level = run;
            if (stst) begin
               next_state = ST_PD_WAIT;
               pd_start   = 1'b1;
            end
         end
         ST_PD_WAIT: begin
            if (!stst) begin
               next_level = run;
               next_state = ST_RUN;
            end else if (pd_done || pd == 8'h00) begin
               if (dnd == 4'h0) begin
                  next_level = hold;
                  next_state = ST_HOLD;
               end else begin
                  next_state = ST_RAMP_DOWN;
                  step_start = 1'b1;
               end
            end
         end
         ST_RAMP_DOWN: begin
            if (motion_req) begin
               next_state = ST_RAMP_UP;
               step_start = 1'b1;
            end else if (dnd == 4'h0 || level == hold) begin
               next_level = hold;
               next_state = ST_HOLD;
            end else if (step_done) begin
               next_level = step_toward(level, hold);
               step_start = 1'b1;
            end
         end
         default: begin
            next_state = ST_HOLD;
            next_level = hold;
         end
      endcase
      next_scale = {1'b0, next_level} + 6'h01;
      next_coil  = COIL_DRIVE;
      if (next_state == ST_HOLD && silent_mode && hold == 5'h00) begin
         next_coil = ctrl[SHORT_BIT] ? COIL_SHORT : COIL_FREE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state     <= ST_HOLD;
         level     <= HOLD_RST;
         cur_scale <= {1'b0, HOLD_RST} + 6'h01;
         coil_mode <= COIL_DRIVE;
         motion_go <= 1'b0;
      end else if (ce) begin
         state     <= next_state;
         level     <= next_level;
         cur_scale <= next_scale;
         coil_mode <= next_coil;
         motion_go <= (next_state == ST_RUN);
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   // The gap counter restarts on each level or state change, so it
   // measures one step or one wait; it saturates rather than wrap.
   logic [26:0] gap, next_gap;

   always_comb begin
      next_gap = (gap == '1) ? gap : gap + 27'h1;
      if (next_level != level || next_state != state) begin
         next_gap = 27'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gap <= 27'h1;
      end else if (ce) begin
         gap <= next_gap;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst || !ce);

   up_step_time_a: assert property (
      state == ST_RAMP_UP && $past(state) == ST_RAMP_UP &&
      level != $past(level) && $stable(upd)
      |-> $past(gap) == 27'(upd) * 27'(UP_UNIT_CLK))
      else $error("Ramp-up step period wrong.");
   instant_up_a: assert property (
      state == ST_HOLD && motion_req && upd == 4'h0
      |=> state == ST_RUN && cur_scale == 6'($past(run)) + 6'h01)
      else $error("Zero ramp-up delay did not apply run at once.");
   dn_step_time_a: assert property (
      state == ST_RAMP_DOWN && $past(state) == ST_RAMP_DOWN &&
      level != $past(level) && $stable(dnd)
      |-> $past(gap) == 27'(dnd) * 27'(LONG_UNIT_CYC))
      else $error("Ramp-down step period wrong.");
   pd_wait_a: assert property (
      $past(state) == ST_PD_WAIT && state != ST_PD_WAIT &&
      state != ST_RUN && $stable(pd)
      |-> $past(stst) && $past(gap) ==
          ((pd == 8'h00) ? 27'h1 : 27'(pd) * 27'(LONG_UNIT_CYC)))
      else $error("Power-down left early or without standstill.");
   run_scale_a: assert property (
      state == ST_RUN |-> cur_scale == 6'($past(run)) + 6'h01)
      else $error("Run current scale wrong.");
   hold_scale_a: assert property (
      state == ST_HOLD && $past(state) != ST_RAMP_UP
      |-> cur_scale == 6'($past(hold)) + 6'h01)
      else $error("Standstill current scale wrong.");
   standstill_opt_a: assert property (
      state == ST_HOLD && $past(silent_mode) && $past(hold) == 5'h00
      |-> coil_mode == ($past(ctrl[SHORT_BIT]) ? COIL_SHORT : COIL_FREE))
      else $error("Standstill option not applied.");
   pd_reset_a: assert property (
      $past(rst) |-> pd == 8'h0A && state == ST_HOLD)
      else $error("Power-down delay reset value wrong.");
   one_step_a: assert property (
      (state == ST_RAMP_UP || state == ST_RAMP_DOWN) &&
      $past(state) == state && level != $past(level)
      |-> level == $past(level) + 5'h01 || level == $past(level) - 5'h01)
      else $error("Ramp step larger than one level.");

endmodule

// ==== mcs_pkg.sv ====
/*
 * Shared constants and types for the motor current hold/run sequencer.
 * Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package mcs_pkg;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ------------------------------------------------------------
   localparam int           ADDR_W      = 12;
   localparam int           IDX_W       = ADDR_W - 2;
   localparam logic [9:0]   IDX_LEVELS  = 10'h047;
   localparam logic [9:0]   IDX_PDOWN   = 10'h048;
   localparam logic [9:0]   IDX_CTRL    = 10'h050;
   localparam logic [9:0]   IDX_STATUS  = 10'h051;

   // ------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------
   localparam int           UPD_LSB     = 24;
   localparam int           DND_LSB     = 16;
   localparam int           RUN_LSB     = 8;
   localparam int           HOLD_LSB    = 0;
   localparam int           PD_LSB      = 0;
   localparam int           SHORT_BIT   = 0;
   localparam int           ST_LSB      = 8;
   localparam int           GO_BIT      = 16;

   // ------------------------------------------------------------
   // Reset values and writable masks.
   // ------------------------------------------------------------
   localparam logic [3:0]   UPD_RST     = 4'h4;
   localparam logic [3:0]   DND_RST     = 4'h1;
   localparam logic [4:0]   RUN_RST     = 5'h1F;
   localparam logic [4:0]   HOLD_RST    = 5'h08;
   localparam logic [7:0]   PD_RST      = 8'h0A;
   localparam logic [31:0]  LEVELS_MASK = 32'h0F0F_1F1F;
   localparam logic [31:0]  PDOWN_MASK  = 32'h0000_00FF;
   localparam logic [31:0]  CTRL_MASK   = 32'h0000_0001;

   // ------------------------------------------------------------
   // Timing, in core clock periods (5 ns each at 200 MHz).
   // ------------------------------------------------------------
   localparam int           CLK_MHZ     = 200;
   localparam int           UP_UNIT_CLK = 512;
   localparam int           DN_UNIT_CLK = 262144;
   localparam int           CNT_W       = 26;

   // ------------------------------------------------------------
   // Bus answers and types.
   // ------------------------------------------------------------
   localparam logic [1:0]   RESP_OKAY   = 2'h0;
   localparam logic [1:0]   RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_HOLD      = 3'h0,
      ST_RAMP_UP   = 3'h1,
      ST_RUN       = 3'h3,
      ST_PD_WAIT   = 3'h2,
      ST_RAMP_DOWN = 3'h6
   } mcs_state_t;

   typedef enum logic [1:0] {
      COIL_DRIVE = 2'h0,
      COIL_FREE  = 2'h1,
      COIL_SHORT = 2'h2
   } mcs_coil_t;

endpackage

// ==== mcs_unit_timer.sv ====
/*
 * Down counter that times a number of units of a given length.
 * Assumes start is a one-cycle request from logic on core_clk.
 */
`timescale 1ns/1ps
module mcs_unit_timer
   import mcs_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         start,
   input  wire logic [7:0]   units,
   input  wire logic [W-1:0] unit_len,
   output logic              done
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   // ------------------------------------------------------------
   // Count.
   // ------------------------------------------------------------
   // Done is combinational so a restart in the same cycle keeps the
   // step period at exactly units times unit_len.
   assign done = (cnt == W'(1));

   always_comb begin
      next_cnt = cnt;
      if (start) begin
         next_cnt = W'(units * unit_len);
      end else if (cnt != '0) begin
         next_cnt = cnt - W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt <= '0;
      end else if (ce) begin
         cnt <= next_cnt;
      end
   end

endmodule

// ==== mcs_axil_slave.sv ====
/*
 * AXI4-Lite slave front end: takes address and data in any order,
 * hands one write or read to the register file, answers in one cycle.
 * Assumes the register file decodes the index combinationally.
 */
`timescale 1ns/1ps
module mcs_axil_slave
   import mcs_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   wr_en,
   output logic [IDX_W-1:0]       wr_idx,
   output logic [31:0]            wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_ok,
   output logic [IDX_W-1:0]       rd_idx,
   input  wire logic [31:0]       rd_data,
   input  wire logic              rd_ok
);

   logic              aw_held, next_aw_held, w_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0]       next_wr_data, next_rdata;
   logic [3:0]        next_wr_strb;
   logic [1:0]        next_bresp, next_rresp;
   logic              next_bvalid, next_rvalid;

   assign wr_idx = aw_addr[ADDR_W-1:2];
   assign rd_idx = araddr[ADDR_W-1:2];
   assign wr_en  = aw_held && w_held && !bvalid;

   // ------------------------------------------------------------
   // Handshakes.
   // ------------------------------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held  = 1'b1;
         next_wr_data = wdata;
         next_wr_strb = wstrb;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_en) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_ok ? rd_data : 32'h0000_0000;
         next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         awready <= 1'b1;
         w_held  <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
         arready <= 1'b1;
      end else if (ce) begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         awready <= !next_aw_held;
         w_held  <= next_w_held;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         wready  <= !next_w_held;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
         arready <= !next_rvalid;
      end
   end

endmodule

// ==== test_mcs_top.sv ====
/*
 * Self-checking bench for the motor current sequencer top.
 * Assumes mcs_pkg and mcs_top are compiled first; one 200 MHz clock.
 */
`timescale 1ns/1ps
module test_mcs_top
   import mcs_pkg::*;
   ();
   // ---------------------------------------------------------------
   // Signals and model state.
   // ---------------------------------------------------------------
   logic              core_clk, rst, ce, stst, motion_req, silent_mode;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic              s_axi_rready, motion_go;
   logic [1:0]        s_axi_bresp, s_axi_rresp, coil_mode;
   logic [5:0]        cur_scale;
   int                error_cnt, total_checks, seed;
   int                run, hold, upd, dnd, pd;

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // A short long-unit keeps the power-down timing inside the run.
   mcs_top #(.LONG_UNIT_CYC(8)) uut (.core_clk, .rst, .ce,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .stst, .motion_req, .silent_mode, .cur_scale,
      .coil_mode, .motion_go);

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] lv();
      return 32'((upd << 24) | (dnd << 16) | (run << 8) | hold);
   endfunction

   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, RESP_OKAY);
   endtask

   task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, d);
      chk("rresp", s_axi_rresp, r);
   endtask

   // Follows the scale to its target, checking each step and its spacing.
   // The scale is taken just before each edge, so the first change shows
   // one edge to take the request, the wait, one step and one edge later.
   task automatic ramp(int tgt, int per, int lo);
      int t, last, prev, n, dir;
      prev = cur_scale;
      dir = (tgt > prev) ? 1 : -1;
      n = 0;
      last = 0;
      for (t = 1; t < 20000 && cur_scale !== tgt[5:0]; t++) begin
         @(posedge core_clk);
         if (cur_scale !== prev[5:0]) begin
            if (per != 0) chk("step", cur_scale, prev + dir);
            if (n > 0) chk("gap", t - last, per);
            else chk("first", t, lo + per + 2);
            n++;
            last = t;
            prev = cur_scale;
         end
      end
      chk("level", cur_scale, tgt);
   endtask

   // ---------------------------------------------------------------
   // Tests.
   // ---------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      seed = 47;
      error_cnt = 0;
      total_checks = 0;
      {rst, ce, stst, motion_req, silent_mode} = 5'h18;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd(12'h11C, 32'h0401_1F08, RESP_OKAY);
      rd(12'h120, 32'h0000_000A, RESP_OKAY);
      rd(12'h200, 32'h0000_0000, RESP_SLVERR);
      chk("idle", cur_scale, 6'h09);
      $display("test reset done");
      run = 16 + ($unsigned($random(seed)) % 16);
      {hold, upd, dnd, pd} = {32'd8, 32'd1, 32'd1, 32'd2};
      wr(12'h11C, lv());
      wr(12'h120, 32'(pd));
      rd(12'h11C, lv(), RESP_OKAY);
      motion_req <= 1'b1;
      ramp(run + 1, upd * 512, 0);
      @(posedge core_clk);
      chk("go", motion_go, 1'b1);
      rd(12'h144, 32'(run) | 32'h0001_0300, RESP_OKAY);
      motion_req <= 1'b0;
      stst <= 1'b1;
      ramp(hold + 1, dnd * 8, pd * 8);
      chk("go", motion_go, 1'b0);
      $display("test stepped ramps done");
      {upd, dnd, run} = {32'd0, 32'd0, 32'd31};
      wr(12'h11C, lv());
      motion_req <= 1'b1;
      stst <= 1'b0;
      ramp(32, 0, 0);
      motion_req <= 1'b0;
      stst <= 1'b1;
      ramp(hold + 1, 0, pd * 8);
      $display("test instant ramps done");
      hold = 0;
      wr(12'h11C, lv());
      wr(12'h140, 32'h1);
      silent_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("coil", coil_mode, COIL_SHORT);
      wr(12'h140, 32'h0);
      repeat (4) @(posedge core_clk);
      chk("coil", coil_mode, COIL_FREE);
      silent_mode <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("coil", coil_mode, COIL_DRIVE);
      $display("test standstill option done");
      wrap_up();
   end
endmodule
